// File: hdl/jump_exec_pkg.sv
package jump_exec_pkg;

   // Opcodes of the four branch instructions handled here
   localparam logic [7:0] OP_BIT_SET_CLEAR = 8'h10;
   localparam logic [7:0] OP_CARRY_SET = 8'h40;
   localparam logic [7:0] OP_TABLE_JUMP = 8'h73;
   localparam logic [7:0] OP_BIT_CLEAR = 8'h30;

   // Instruction lengths in bytes
   localparam logic [15:0] LEN_BIT_JUMP = 16'h0003;
   localparam logic [15:0] LEN_CARRY_JUMP = 16'h0002;

   // Timing: clocks per machine cycle and machine cycles per instruction
   localparam int CLKS_PER_MCYCLE = 12;
   localparam int MCYCLES_PER_JUMP = 2;
   localparam int JUMP_CLKS = CLKS_PER_MCYCLE * MCYCLES_PER_JUMP;
   localparam logic [7:0] JUMP_LAST_CLK = 8'(JUMP_CLKS - 1);

   // Bit address map: below the split lies the internal RAM bit region
   localparam logic [7:0] BIT_SFR_SPLIT = 8'h80;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam logic [7:0] BIT_SFR_MASK = 8'hf8;
   localparam int BIT_IDX_LSB = 0;
   localparam int BIT_IDX_MSB = 2;
   localparam int BIT_RAM_ROW_LSB = 3;
   localparam int BIT_RAM_ROW_MSB = 6;

   // Sixteen-bit data pointer as two bytes
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } data_pointer_16_s;

   // Decoded location of one addressable bit
   typedef struct packed {
      logic is_sfr;
      logic [7:0] byte_addr;
      logic [2:0] bit_idx;
   } bit_loc_s;

endpackage

// File: hdl/bit_addr_decode.sv
`timescale 1ns/10ps
`default_nettype none

// Maps a bit-address byte onto a RAM or special register byte and bit index
module bit_addr_decode (
   input wire logic [7:0] bit_addr_i, // Bit-address byte of the instruction
   output var jump_exec_pkg::bit_loc_s loc_o // Decoded byte and bit position
);

   // Low half selects RAM rows, high half selects register bytes
   always_comb begin
      loc_o.bit_idx = bit_addr_i[jump_exec_pkg::BIT_IDX_MSB:jump_exec_pkg::BIT_IDX_LSB];
      if (bit_addr_i < jump_exec_pkg::BIT_SFR_SPLIT) begin
         // RAM bit region, eight bits per row
         loc_o.is_sfr = 1'b0;
         loc_o.byte_addr = jump_exec_pkg::BIT_RAM_BASE
            + {4'h0, bit_addr_i[jump_exec_pkg::BIT_RAM_ROW_MSB:jump_exec_pkg::BIT_RAM_ROW_LSB]};
      end else begin
         // Register byte on an eight-aligned address
         loc_o.is_sfr = 1'b1;
         loc_o.byte_addr = bit_addr_i & jump_exec_pkg::BIT_SFR_MASK;
      end
   end

endmodule

`default_nettype wire

// File: hdl/conditional_jump_execution.sv
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Bit-set-then-clear jump: 0x10, three bytes, two cycles
// - Bit-set-then-clear jump branches when bit is one
// - Bit-set-then-clear jump leaves tested bit at zero
// - Bit jump target: PC plus three plus offset
// - Set-then-clear jump reads port bits from output latch, not pin; bit-clear jump reads the pin
// - Carry jump: 0x40, two bytes, branches on carry
// - Carry jump target: PC plus two plus offset
// - Table jump loads accumulator plus data pointer
// - Table jump sum wraps at sixteen bits
// - Table jump keeps accumulator and data pointer
// - Table jump: 0x73, one byte, two cycles
// - Bit-clear jump: 0x30, three bytes, branch on zero
// - Bit-clear jump never writes the tested bit
// - No jump changes any status flag
// - Data pointer low byte carries into high byte
module conditional_jump_execution (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic start_i, // Opcode present, begin execution
   input wire logic [7:0] opcode_i, // Opcode byte already fetched
   input wire logic [15:0] pc_i, // Address of the opcode byte
   input wire logic [7:0] accumulator_reg_i, // Accumulator contents
   input wire jump_exec_pkg::data_pointer_16_s data_pointer_16_i, // Data pointer
   input wire logic carry_i, // Carry flag
   output logic busy_o, // Instruction in progress
   output logic pm_rd_o, // Program memory read strobe
   output logic [15:0] pm_addr_o, // Program memory address
   input wire logic [7:0] pm_data_i, // Program byte, one cycle after strobe
   output logic bit_rd_o, // Bit read strobe
   output logic bit_latch_o, // Read the output latch rather than the pin
   output var jump_exec_pkg::bit_loc_s bit_loc_o, // Bit location for read and write
   input wire logic bit_rdata_i, // Bit value, one cycle after read strobe
   output logic bit_wr_o, // Bit write strobe
   output logic bit_wdata_o, // Bit write value
   output logic done_o, // Instruction complete, load new PC
   output logic [15:0] pc_new_o // Next program counter value
);

   // Execution sequence
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH_A,
      ST_FETCH_B,
      ST_BIT_RD,
      ST_BIT_EVAL,
      ST_WAIT
   } exec_state_e;

   exec_state_e state_r, state_nxt; // Sequencer state
   logic [7:0] op_r, op_nxt; // Opcode being executed
   logic [15:0] pc_r, pc_nxt; // Opcode address
   logic [15:0] pm_addr_r, pm_addr_nxt; // Program fetch address
   logic [7:0] rel_r, rel_nxt; // Signed displacement
   logic bit_r, bit_nxt; // Tested bit or carry
   logic [7:0] acc_r, acc_nxt; // Accumulator sample
   logic [15:0] data_pointer_16_r, data_pointer_16_nxt; // Data pointer sample
   logic [7:0] cyc_r, cyc_nxt; // Clocks since start
   logic [15:0] pc_new_r, pc_new_nxt; // Computed target
   jump_exec_pkg::bit_loc_s loc_r, loc_nxt; // Registered bit location
   jump_exec_pkg::bit_loc_s loc_dec; // Decoder result
   logic op_ok; // Opcode belongs to this block
   logic is_bit_op; // Three-byte bit jump
   logic is_bsc_r; // Bit-set-then-clear in progress
   logic [15:0] seq_pc; // Address of the following instruction
   logic [15:0] rel_ext; // Sign-extended displacement
   logic taken; // Branch condition met

   // Bit-address decoder fed by the byte arriving from program memory
   bit_addr_decode u_bit_decode (
      .bit_addr_i(pm_data_i),
      .loc_o(loc_dec)
   );

   // Opcode classification
   assign op_ok = (opcode_i == jump_exec_pkg::OP_BIT_SET_CLEAR)
      || (opcode_i == jump_exec_pkg::OP_CARRY_SET)
      || (opcode_i == jump_exec_pkg::OP_TABLE_JUMP)
      || (opcode_i == jump_exec_pkg::OP_BIT_CLEAR);
   assign is_bit_op = (op_r == jump_exec_pkg::OP_BIT_SET_CLEAR) || (op_r == jump_exec_pkg::OP_BIT_CLEAR);
   assign is_bsc_r = (op_r == jump_exec_pkg::OP_BIT_SET_CLEAR);

   // Sequential address and branch condition
   always_comb begin
      // Advance past the instruction first, then add the offset
      seq_pc = is_bit_op ? pc_r + jump_exec_pkg::LEN_BIT_JUMP : pc_r + jump_exec_pkg::LEN_CARRY_JUMP;
      rel_ext = {{8{rel_r[7]}}, rel_r};
      if (op_r == jump_exec_pkg::OP_BIT_CLEAR) begin
         taken = ~bit_r;
      end else begin
         taken = bit_r;
      end
   end

   // Next-state and datapath computation
   always_comb begin
      state_nxt = state_r;
      op_nxt = op_r;
      pc_nxt = pc_r;
      pm_addr_nxt = pm_addr_r;
      rel_nxt = rel_r;
      bit_nxt = bit_r;
      acc_nxt = acc_r;
      data_pointer_16_nxt = data_pointer_16_r;
      cyc_nxt = cyc_r;
      pc_new_nxt = pc_new_r;
      loc_nxt = loc_r;
      case (state_r)
         ST_IDLE: begin
            cyc_nxt = 8'h00;
            if (start_i && op_ok) begin
               // Sample operands; flags and pointer are only read
               op_nxt = opcode_i;
               pc_nxt = pc_i;
               pm_addr_nxt = pc_i + 16'h0001;
               acc_nxt = accumulator_reg_i;
               data_pointer_16_nxt = {data_pointer_16_i.high, data_pointer_16_i.low};
               bit_nxt = carry_i;
               if (opcode_i == jump_exec_pkg::OP_TABLE_JUMP) begin
                  state_nxt = ST_WAIT; // Single-byte instruction
               end else begin
                  state_nxt = ST_FETCH_A;
               end
            end
         end
         ST_FETCH_A: begin
            // Second byte requested this cycle
            cyc_nxt = cyc_r + 8'h01;
            pm_addr_nxt = pc_r + 16'h0002;
            state_nxt = ST_FETCH_B;
         end
         ST_FETCH_B: begin
            cyc_nxt = cyc_r + 8'h01;
            if (is_bit_op) begin
               // Second byte is the bit address
               loc_nxt = loc_dec;
               state_nxt = ST_BIT_RD;
            end else begin
               // Second byte is the displacement
               rel_nxt = pm_data_i;
               state_nxt = ST_WAIT;
            end
         end
         ST_BIT_RD: begin
            // Third byte is the displacement
            cyc_nxt = cyc_r + 8'h01;
            rel_nxt = pm_data_i;
            state_nxt = ST_BIT_EVAL;
         end
         ST_BIT_EVAL: begin
            cyc_nxt = cyc_r + 8'h01;
            bit_nxt = bit_rdata_i;
            state_nxt = ST_WAIT;
         end
         ST_WAIT: begin
            cyc_nxt = cyc_r + 8'h01;
            if (op_r == jump_exec_pkg::OP_TABLE_JUMP) begin
               // Full sixteen-bit wrapping sum
               pc_new_nxt = {8'h00, acc_r} + data_pointer_16_r;
            end else if (taken) begin
               pc_new_nxt = seq_pc + rel_ext;
            end else begin
               pc_new_nxt = seq_pc;
            end
            if (cyc_r == jump_exec_pkg::JUMP_LAST_CLK) begin
               // Two machine cycles elapsed
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         op_r <= 8'h00;
         pc_r <= 16'h0000;
         pm_addr_r <= 16'h0000;
         rel_r <= 8'h00;
         bit_r <= 1'b0;
         acc_r <= 8'h00;
         data_pointer_16_r <= 16'h0000;
         cyc_r <= 8'h00;
         pc_new_r <= 16'h0000;
         loc_r <= '0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         pc_r <= pc_nxt;
         pm_addr_r <= pm_addr_nxt;
         rel_r <= rel_nxt;
         bit_r <= bit_nxt;
         acc_r <= acc_nxt;
         data_pointer_16_r <= data_pointer_16_nxt;
         cyc_r <= cyc_nxt;
         pc_new_r <= pc_new_nxt;
         loc_r <= loc_nxt;
      end
   end

   // Strobes and outputs
   assign busy_o = (state_r != ST_IDLE);
   assign pm_rd_o = (state_r == ST_FETCH_A) || ((state_r == ST_FETCH_B) && is_bit_op);
   assign pm_addr_o = pm_addr_r;
   assign bit_rd_o = (state_r == ST_BIT_RD);
   // Read-modify-write takes the latch value
   assign bit_latch_o = is_bsc_r;
   assign bit_loc_o = loc_r;
   // Clear only on the set-then-clear jump; a zero bit already stays zero
   assign bit_wr_o = (state_r == ST_BIT_EVAL) && is_bsc_r && bit_rdata_i;
   assign bit_wdata_o = 1'b0;
   assign done_o = (state_r == ST_WAIT) && (cyc_r == jump_exec_pkg::JUMP_LAST_CLK);
   assign pc_new_o = pc_new_r;

   // Any write clears the bit and belongs to the set-then-clear jump
   a_clear_write_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      bit_wr_o |-> (!bit_wdata_o && is_bsc_r && $past(bit_rd_o)))
      else $error("bit write not a clear from set-then-clear jump");

   // Bit-clear jump never writes
   a_bit_clear_nowr: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (busy_o && op_r == jump_exec_pkg::OP_BIT_CLEAR) |-> !bit_wr_o)
      else $error("bit-clear jump wrote the tested bit");

   // Set-then-clear jump reads the latch
   a_latch_read_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (bit_rd_o && is_bsc_r) |-> bit_latch_o)
      else $error("set-then-clear jump read the pin");

   // Completion exactly two machine cycles after start
   a_done_two_cycles: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (!busy_o && start_i && op_ok) |-> ##24 done_o)
      else $error("jump did not complete in two machine cycles");

   // Table jump target is accumulator plus data pointer at start
   a_table_sum: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (done_o && op_r == jump_exec_pkg::OP_TABLE_JUMP)
      |-> (pc_new_o == 16'({8'h00, $past(accumulator_reg_i, 24)} + $past(data_pointer_16_i, 24))))
      else $error("table jump target wrong");

   // Carry jump target
   a_carry_target: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (done_o && op_r == jump_exec_pkg::OP_CARRY_SET)
      |-> (pc_new_o == 16'(pc_r + 16'h0002 + (bit_r ? {{8{rel_r[7]}}, rel_r} : 16'h0000))))
      else $error("carry jump target wrong");

   // Bit jump targets for both polarities
   a_bit_target: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (done_o && is_bit_op)
      |-> (pc_new_o == 16'(pc_r + 16'h0003
         + ((bit_r ^ (op_r == jump_exec_pkg::OP_BIT_CLEAR)) ? {{8{rel_r[7]}}, rel_r} : 16'h0000))))
      else $error("bit jump target wrong");

   // Third byte fetched from opcode address plus two
   a_third_fetch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (pm_rd_o && state_r == ST_FETCH_B) |-> (pm_addr_o == 16'(pc_r + 16'h0002)))
      else $error("third byte fetched from wrong address");

   // Completion returns the sequencer to idle at once
   a_done_then_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      done_o |=> !busy_o)
      else $error("still busy after completion");

   // No early end and no restart while an instruction runs
   a_busy_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (busy_o && !done_o) |=> busy_o)
      else $error("instruction ended before its last clock");

   // Table jump is a single byte and touches no bit
   a_table_no_fetch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (busy_o && op_r == jump_exec_pkg::OP_TABLE_JUMP) |-> (!pm_rd_o && !bit_rd_o && !bit_wr_o))
      else $error("table jump fetched or accessed a bit");

   // Carry jump fetches only its offset byte and no bit
   a_carry_one_fetch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (busy_o && op_r == jump_exec_pkg::OP_CARRY_SET)
      |-> (!bit_rd_o && !bit_wr_o && (!pm_rd_o || pm_addr_o == 16'(pc_r + 16'h0001))))
      else $error("carry jump fetched beyond its two bytes");

   // Bit jumps read the addressed bit in their third clock
   a_bit_read_slot: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (!busy_o && start_i && (opcode_i == jump_exec_pkg::OP_BIT_SET_CLEAR
         || opcode_i == jump_exec_pkg::OP_BIT_CLEAR)) |-> ##3 bit_rd_o)
      else $error("bit jump did not read its bit in time");

   // Bit location follows the second instruction byte
   a_bit_loc_decode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      bit_rd_o |-> (bit_loc_o.bit_idx == $past(pm_data_i[2:0]) && bit_loc_o.is_sfr == $past(pm_data_i[7])))
      else $error("bit location does not match bit-address byte");

   // Set-then-clear jump clears exactly when the bit read one
   a_clear_when_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (op_r == jump_exec_pkg::OP_BIT_SET_CLEAR && bit_rd_o) |=> (bit_wr_o == bit_rdata_i))
      else $error("set bit not cleared by set-then-clear jump");

   // New program counter stands while idle
   a_target_stands: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !busy_o |-> $stable(pc_new_o))
      else $error("next program counter changed while idle");

endmodule

`default_nettype wire

// File: test/jump_far_side_model.sv
`timescale 1ns/10ps
`default_nettype none

// Program memory and bit space that answer the jump block one cycle after each strobe
module jump_far_side_model (
   input wire logic core_clk_i, // Core clock
   input wire logic pm_rd_i, // Program read strobe
   input wire logic [15:0] pm_addr_i, // Program read address
   output logic [7:0] pm_data_o, // Program byte
   input wire logic bit_rd_i, // Bit read strobe
   input wire logic bit_latch_i, // Read port latch instead of pin
   input wire jump_exec_pkg::bit_loc_s bit_loc_i, // Bit location
   output logic bit_rdata_o, // Bit value
   input wire logic bit_wr_i, // Bit write strobe
   input wire logic bit_wdata_i // Bit write value
);
   logic [7:0] prog_mem [0:65535]; // Program bytes, loaded by the bench
   logic [7:0] latch_mem [0:255]; // Bit space bytes, output latch for ports
   logic is_port; // Addressed byte is a port with a pin of its own

   assign is_port = bit_loc_i.is_sfr && (bit_loc_i.byte_addr[3:0] == 4'h0) && (bit_loc_i.byte_addr[7:6] == 2'h2);

   // Idle lines show a changing pattern so a late sample gives a wrong value
   initial begin
      pm_data_o = 8'h5a;
      bit_rdata_o = 1'b0;
   end

   // Answers and writes, registered on the core clock
   always @(posedge core_clk_i) begin
      if (pm_rd_i) begin
         pm_data_o <= prog_mem[pm_addr_i];
      end else begin
         pm_data_o <= ~pm_data_o;
      end
      // A port pin reads opposite to its latch so the wrong source shows
      if (bit_rd_i) begin
         bit_rdata_o <= latch_mem[bit_loc_i.byte_addr][bit_loc_i.bit_idx] ^ (is_port && !bit_latch_i);
      end else begin
         bit_rdata_o <= ~bit_rdata_o;
      end
      // Write-back of the tested bit
      if (bit_wr_i) begin
         latch_mem[bit_loc_i.byte_addr][bit_loc_i.bit_idx] <= bit_wdata_i;
      end
   end
endmodule
`default_nettype wire

// File: test/conditional_jump_execution_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("Error %0t: got %h expected %h", $time, a, b); end end

// Self-checking bench: driver notes each expectation, monitor compares at done
module conditional_jump_execution_test;
   typedef struct {
      logic [15:0] pc;
      logic [7:0] byte_a;
      logic [2:0] idx;
      logic bitv;
   } exp_note_s; // Expected next PC and tested bit afterwards

   logic core_clk_i = 1'b0; // Core clock
   logic rst_n_i = 1'b0; // Reset, active low
   logic start_i = 1'b0; // Start request
   logic [7:0] opcode_i = 8'h00; // Opcode
   logic [15:0] pc_i = 16'h0000; // Opcode address
   logic [7:0] acc_i = 8'h00; // Accumulator
   jump_exec_pkg::data_pointer_16_s dp_i = '0; // Data pointer
   logic carry_i = 1'b0; // Carry flag
   logic busy_o, pm_rd_o, bit_rd_o, bit_latch_o, bit_wr_o, bit_wdata_o, done_o, bit_rdata_i;
   logic [15:0] pm_addr_o, pc_new_o;
   logic [7:0] pm_data_i;
   jump_exec_pkg::bit_loc_s bit_loc_o;
   int error_cnt = 0; // Mismatches
   int checks = 0; // Comparisons
   int busy_cnt = 0; // Busy cycles of the current instruction
   exp_note_s exp_q[$]; // Outstanding expectations
   logic [7:0] ops [0:3] = '{8'h10, 8'h40, 8'h73, 8'h30}; // Supported opcodes

   conditional_jump_execution conditional_jump_execution_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .start_i(start_i), .opcode_i(opcode_i), .pc_i(pc_i), .accumulator_reg_i(acc_i), .data_pointer_16_i(dp_i),
      .carry_i(carry_i), .busy_o(busy_o), .pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i),
      .bit_rd_o(bit_rd_o), .bit_latch_o(bit_latch_o), .bit_loc_o(bit_loc_o), .bit_rdata_i(bit_rdata_i),
      .bit_wr_o(bit_wr_o), .bit_wdata_o(bit_wdata_o), .done_o(done_o), .pc_new_o(pc_new_o));

   jump_far_side_model jump_far_side_model_i (.core_clk_i(core_clk_i), .pm_rd_i(pm_rd_o), .pm_addr_i(pm_addr_o),
      .pm_data_o(pm_data_i), .bit_rd_i(bit_rd_o), .bit_latch_i(bit_latch_o), .bit_loc_i(bit_loc_o),
      .bit_rdata_o(bit_rdata_i), .bit_wr_i(bit_wr_o), .bit_wdata_i(bit_wdata_o));

   // Clock at 25 MHz
   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end

   // Verdict and end of run
   task automatic stop_test();
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // One instruction: preload memories, note expectation, start, hold junk start while busy
   task automatic run_one(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] baddr,
                          input logic [7:0] off, input logic v, input logic c, input logic [7:0] acc,
                          input logic [15:0] dp);
      exp_note_s n;
      logic tested;
      logic take;
      logic [15:0] seq;
      @(posedge core_clk_i);
      n.byte_a = (baddr < 8'h80) ? (8'h20 + {4'h0, baddr[6:3]}) : (baddr & 8'hf8);
      n.idx = baddr[2:0];
      tested = (baddr[7] && n.byte_a[3:0] == 4'h0 && n.byte_a[7:6] == 2'h2 && op != 8'h10) ? ~v : v;
      jump_far_side_model_i.latch_mem[n.byte_a][n.idx] = v;
      jump_far_side_model_i.prog_mem[pc + 16'h0001] = (op == 8'h40) ? off : baddr;
      jump_far_side_model_i.prog_mem[pc + 16'h0002] = off;
      take = 1'b0;
      seq = pc + jump_exec_pkg::LEN_BIT_JUMP;
      case (op)
         8'h10: take = tested; // Branch on a set bit
         8'h30: take = ~tested; // Branch on a clear bit
         8'h40: begin // Branch on carry, two bytes
            take = c;
            seq = pc + jump_exec_pkg::LEN_CARRY_JUMP;
         end
         default: seq = {8'h00, acc} + dp; // Table jump
      endcase
      n.pc = take ? seq + {{8{off[7]}}, off} : seq;
      n.bitv = (op == 8'h10) ? 1'b0 : v;
      exp_q.push_back(n);
      start_i <= 1'b1;
      opcode_i <= op;
      pc_i <= pc;
      acc_i <= acc;
      dp_i <= dp;
      carry_i <= c;
      @(posedge core_clk_i);
      opcode_i <= jump_exec_pkg::OP_TABLE_JUMP;
      pc_i <= ~pc;
      acc_i <= ~acc;
      dp_i <= ~dp;
      carry_i <= ~c;
      for (int k = 0; k < 40; k++) begin
         @(negedge core_clk_i);
         if (done_o === 1'b1) break;
      end
   endtask

   // Monitor: compare every completion with the oldest note
   initial begin
      exp_note_s n;
      forever begin
         @(negedge core_clk_i);
         busy_cnt = (busy_o === 1'b1) ? busy_cnt + 1 : 0;
         if (done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
               `CHK(1'b1, 1'b0)
            end else begin
               n = exp_q.pop_front();
               `CHK(pc_new_o, n.pc)
               `CHK(jump_far_side_model_i.latch_mem[n.byte_a][n.idx], n.bitv)
               `CHK(busy_cnt, jump_exec_pkg::JUMP_CLKS)
            end
         end
      end
   end

   // Watchdog
   initial begin
      #(40 * 3000);
      error_cnt++;
      stop_test();
   end

   // Main sequence
   initial begin
      logic [7:0] op;
      void'($urandom(88984));
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      start_i <= 1'b1;
      opcode_i <= 8'h20;
      @(posedge core_clk_i);
      start_i <= 1'b0;
      @(negedge core_clk_i);
      `CHK(busy_o, 1'b0)
      run_one(8'h10, 16'h1000, 8'h93, 8'hfe, 1'b1, 1'b0, 8'h00, 16'h0000);
      run_one(8'h10, 16'hfffe, 8'h05, 8'h10, 1'b0, 1'b1, 8'h00, 16'h0000);
      run_one(8'h30, 16'h2000, 8'h93, 8'h80, 1'b1, 1'b0, 8'h00, 16'h0000);
      run_one(8'h73, 16'h3000, 8'h00, 8'h00, 1'b0, 1'b1, 8'hff, 16'h12fe);
      run_one(8'h73, 16'h3000, 8'h00, 8'h00, 1'b0, 1'b0, 8'h02, 16'hffff);
      run_one(8'h40, 16'h4000, 8'h00, 8'h7f, 1'b0, 1'b1, 8'h00, 16'h0000);
      for (int i = 0; i < 40; i++) begin
         op = ops[$urandom() % 4];
         run_one(op, 16'($urandom()), 8'($urandom()), 8'($urandom()), 1'($urandom()), 1'($urandom()),
                 8'($urandom()), 16'($urandom()));
      end
      @(posedge core_clk_i);
      start_i <= 1'b0;
      repeat (30) @(posedge core_clk_i);
      `CHK(exp_q.size(), 0)
      stop_test();
   end
endmodule
`default_nettype wire
